// *** logic/dtf_device.sv ***
`timescale 1ns/1ps
`default_nettype none
module dtf_device
  import dtf_pkg::*;
#(
  parameter int P_READ_LATENCY  = READ_LATENCY_CYC,
  parameter int P_WRITE_LATENCY = WRITE_LATENCY_CYC,
  parameter int P_PREAMBLE      = PREAMBLE_CYC,
  parameter int P_FIFO_DEPTH    = FIFO_DEPTH
) (
  input  wire logic        I_CLK,
  input  wire logic        I_RESETN,
  dtf_link_if.device       LINK,
  input  wire logic [7:0]  I_PATTERN_FIRST_BYTE,
  input  wire logic [7:0]  I_PATTERN_SECOND_BYTE,
  input  wire logic [7:0]  I_INVERT_MASK_LOWER_BYTE,
  input  wire logic [7:0]  I_INVERT_MASK_UPPER_BYTE,
  input  wire logic        I_MASK_FUNCTION_DISABLE,
  input  wire logic        I_WRITE_INVERSION_EN,
  input  wire logic        I_READ_INVERSION_EN,
  output logic [2:0]       O_WR_PTR,
  output logic [2:0]       O_RD_PTR
);
  if (P_PREAMBLE < 1 || P_READ_LATENCY < P_PREAMBLE + 1 || P_WRITE_LATENCY < 2 ||
      P_FIFO_DEPTH < 2 || P_FIFO_DEPTH > 8) begin : g_bad_param
    $error("dtf_device: latency, preamble or depth out of range");
  end

  typedef enum logic [1:0] {DV_IDLE = 2'b01, DV_ARMED = 2'b10} dtf_dev_state_type;
  typedef enum logic [1:0] {FN_CAL = 2'h0, FN_RD_FIFO = 2'h1, FN_WR_FIFO = 2'h2} dtf_func_type;

  dtf_dev_state_type        state_reg,    state_next;
  dtf_func_type             func_reg,     func_next;
  logic [P_READ_LATENCY-1:0]  rpipe_reg,  rpipe_next;
  logic [P_READ_LATENCY-1:0]  rfifo_reg,  rfifo_next;
  logic [P_WRITE_LATENCY-1:0] wpipe_reg,  wpipe_next;
  logic [2:0]               wr_ptr_reg,   wr_ptr_next;
  logic [2:0]               rd_ptr_reg,   rd_ptr_next;
  logic                     act_reg,      act_next;
  logic [3:0]               beat_reg,     beat_next;
  logic                     is_fifo_reg,  is_fifo_next;
  logic [2:0]               entry_reg,    entry_next;
  logic                     cap_reg,      cap_next;
  logic [3:0]               cap_beat_reg, cap_beat_next;
  logic [DQ_W-1:0]          dq_reg,       dq_next;
  logic                     dq_oe_reg,    dq_oe_next;
  logic [MIL_W-1:0]         mil_reg,      mil_next;
  logic                     mil_oe_reg,   mil_oe_next;
  logic                     rdqs_reg,     rdqs_next;
  logic [LANE_W-1:0]        fifo_reg  [P_FIFO_DEPTH][BURST_BEATS];
  logic [LANE_W-1:0]        fifo_next [P_FIFO_DEPTH][BURST_BEATS];

  function automatic logic [2:0] ptr_inc(input logic [2:0] p);
    return (p == 3'(P_FIFO_DEPTH - 1)) ? 3'h0 : 3'(p + 3'h1);
  endfunction : ptr_inc

  // Pattern beat for all lanes; mask lanes carry the bare bit
  function automatic logic [LANE_W-1:0] cal_beat(input logic [3:0] b);
    logic [7:0] byte_sel;
    logic       bit_val;
    byte_sel = b[3] ? I_PATTERN_SECOND_BYTE : I_PATTERN_FIRST_BYTE;
    bit_val  = byte_sel[b[2:0]];
    return {{MIL_W{bit_val}},
            {DQ_W{bit_val}} ^ {I_INVERT_MASK_UPPER_BYTE, I_INVERT_MASK_LOWER_BYTE}};
  endfunction : cal_beat

  logic              train_cmd;
  logic              rd_launch;
  logic              wr_launch;
  logic              burst_start;
  logic              burst_go;
  logic              pre_window;
  logic [3:0]        out_beat;
  logic [2:0]        out_entry;
  logic              out_fifo;
  logic [LANE_W-1:0] lanes;

  always_comb begin
    state_next = state_reg;
    func_next  = func_reg;
    rd_launch  = 1'b0;
    wr_launch  = 1'b0;
    // select bit low is a no-operation
    train_cmd  = (LINK.cmd == CMD_MULTI) && LINK.cmd_op[TRAINING_SELECT_BIT];
    if (train_cmd) begin
      case (LINK.cmd_op[5:0])
        TRN_RD_CAL: begin
          state_next = DV_ARMED;
          func_next  = FN_CAL;
        end
        TRN_RD_FIFO: begin
          state_next = DV_ARMED;
          func_next  = FN_RD_FIFO;
        end
        TRN_WR_FIFO: begin
          state_next = DV_ARMED;
          func_next  = FN_WR_FIFO;
        end
        default: state_next = DV_IDLE;
      endcase
    end else begin
      case (state_reg)
        DV_IDLE: state_next = DV_IDLE;
        DV_ARMED: begin
          // only an immediate CAS2 fires the function
          state_next = DV_IDLE;
          if (LINK.cmd == CMD_CAS2) begin
            rd_launch = (func_reg != FN_WR_FIFO);
            wr_launch = (func_reg == FN_WR_FIFO);
          end
        end
        default: state_next = DV_IDLE;
      endcase
    end
  end

  always_comb begin
    // same read latency for calibration and FIFO reads
    rpipe_next  = {rpipe_reg[P_READ_LATENCY-2:0], rd_launch};
    rfifo_next  = {rfifo_reg[P_READ_LATENCY-2:0], rd_launch && (func_reg == FN_RD_FIFO)};
    wpipe_next  = {wpipe_reg[P_WRITE_LATENCY-2:0], wr_launch};
    burst_start = rpipe_reg[P_READ_LATENCY-1];
    // toggling preamble ahead of the first beat
    pre_window  = |rpipe_reg[P_READ_LATENCY-2 -: P_PREAMBLE];
    burst_go    = burst_start || (act_reg && (beat_reg != 4'hf));
    out_beat    = burst_start ? 4'h0 : 4'(beat_reg + 4'h1);
    out_fifo    = burst_start ? rfifo_reg[P_READ_LATENCY-1] : is_fifo_reg;
    out_entry   = burst_start ? rd_ptr_reg : entry_reg;
    // calibration data goes out with no bus inversion
    // FIFO reads only look, whatever the entry holds
    lanes       = out_fifo ? fifo_reg[out_entry][out_beat] : cal_beat(out_beat);
    act_next     = burst_go;
    beat_next    = burst_go ? out_beat : 4'h0;
    is_fifo_next = out_fifo;
    entry_next   = out_entry;
    dq_next      = burst_go ? lanes[DQ_W-1:0] : '0;
    dq_oe_next   = burst_go;
    mil_next     = burst_go ? lanes[LANE_W-1:DQ_W] : '0;
    // mask lanes float only with all three functions off
    mil_oe_next  = burst_go && (!I_MASK_FUNCTION_DISABLE || I_WRITE_INVERSION_EN ||
                                I_READ_INVERSION_EN);
    rdqs_next    = (burst_go || pre_window) ? !rdqs_reg : 1'b0;
  end

  always_comb begin
    cap_next      = wpipe_reg[P_WRITE_LATENCY-1] || (cap_reg && (cap_beat_reg != 4'hf));
    cap_beat_next = cap_reg ? 4'(cap_beat_reg + 4'h1) : 4'h0;
    fifo_next     = fifo_reg;
    wr_ptr_next   = wr_ptr_reg;
    rd_ptr_next   = rd_ptr_reg;
    if (cap_reg) begin
      // beat stored in the entry at the write pointer
      fifo_next[wr_ptr_reg][cap_beat_reg] = {LINK.mil_bus, LINK.dq_bus};
      if (cap_beat_reg == 4'hf) begin
        // modulo advance makes the sixth write overwrite entry zero
        wr_ptr_next = ptr_inc(wr_ptr_reg);
      end
    end
    // each FIFO read moves to the next entry, wrapping
    if (burst_start && rfifo_reg[P_READ_LATENCY-1]) begin
      rd_ptr_next = ptr_inc(rd_ptr_reg);
    end
    if (LINK.cmd == CMD_READ) begin
      wr_ptr_next = ptr_inc(wr_ptr_next);
      rd_ptr_next = ptr_inc(rd_ptr_next);
    end
    if (LINK.cmd == CMD_PD_ENTRY || LINK.cmd == CMD_SREF_PD_ENTRY) begin
      wr_ptr_next = 3'h0;
      rd_ptr_next = 3'h0;
    end
  end

  always_ff @(posedge I_CLK) begin
    if (!I_RESETN) begin
      state_reg    <= DV_IDLE;
      func_reg     <= FN_CAL;
      rpipe_reg    <= '0;
      rfifo_reg    <= '0;
      wpipe_reg    <= '0;
      wr_ptr_reg   <= 3'h0;
      rd_ptr_reg   <= 3'h0;
      act_reg      <= 1'b0;
      beat_reg     <= 4'h0;
      is_fifo_reg  <= 1'b0;
      entry_reg    <= 3'h0;
      cap_reg      <= 1'b0;
      cap_beat_reg <= 4'h0;
      dq_reg       <= '0;
      dq_oe_reg    <= 1'b0;
      mil_reg      <= '0;
      mil_oe_reg   <= 1'b0;
      rdqs_reg     <= 1'b0;
      for (int e = 0; e < P_FIFO_DEPTH; e++) begin
        for (int b = 0; b < BURST_BEATS; b++) begin
          fifo_reg[e][b] <= '0;
        end
      end
    end else begin
      state_reg    <= state_next;
      func_reg     <= func_next;
      rpipe_reg    <= rpipe_next;
      rfifo_reg    <= rfifo_next;
      wpipe_reg    <= wpipe_next;
      wr_ptr_reg   <= wr_ptr_next;
      rd_ptr_reg   <= rd_ptr_next;
      act_reg      <= act_next;
      beat_reg     <= beat_next;
      is_fifo_reg  <= is_fifo_next;
      entry_reg    <= entry_next;
      cap_reg      <= cap_next;
      cap_beat_reg <= cap_beat_next;
      dq_reg       <= dq_next;
      dq_oe_reg    <= dq_oe_next;
      mil_reg      <= mil_next;
      mil_oe_reg   <= mil_oe_next;
      rdqs_reg     <= rdqs_next;
      fifo_reg     <= fifo_next;
    end
  end

  assign LINK.dev_dq_o   = dq_reg;
  assign LINK.dev_dq_oe  = dq_oe_reg;
  assign LINK.dev_mil_o  = mil_reg;
  assign LINK.dev_mil_oe = mil_oe_reg;
  assign LINK.dev_rdqs   = rdqs_reg;
  assign O_WR_PTR        = wr_ptr_reg;
  assign O_RD_PTR        = rd_ptr_reg;
endmodule : dtf_device
`default_nettype wire

// *** logic/dtf_pkg.sv ***
// What this block does
// - Calibration reads may repeat every col_to_col_delay
// - Keep read_to_train_read_delay between calibration and reads
// - Calibration burst: read latency, 16 beats, preamble
// - First then second pattern byte on all lanes
// - Each pattern byte goes out LSB first
// - Mask lanes are never inverted
// - Mask lanes float only when all functions disabled
// - No bus inversion on calibration burst
// - Wait pd_exit_calib_wait after power-down exit
// - Training select bit low means no operation
// - Select bit high decodes function; others reserved
// - Training command followed at once by CAS2
// - CAS2 operands driven low after training command
// - FIFO write uses write latency from CAS2
// - FIFO read uses read latency from CAS2
// - FIFO holds five 16-beat entries per lane
// - FIFO reads do not alter stored entries
// - Unwritten entries read as plain levels, no error
// - Reads step entries zero to four, then wrap
// - Data lane inverted where its mask bit set
// - Pointers cleared by reset and power-down entries
// - Ordinary read advances both FIFO pointers
// - Sixth FIFO write overwrites the first entry
package dtf_pkg;
  localparam int DQ_W         = 16;
  localparam int MIL_W        = 2;
  localparam int LANE_W       = DQ_W + MIL_W;
  localparam int BURST_BEATS  = 16;
  localparam int FIFO_DEPTH   = 5;
  localparam int READ_LATENCY_CYC  = 8;
  localparam int WRITE_LATENCY_CYC = 6;
  localparam int PREAMBLE_CYC      = 2;
  localparam int CLK_PERIOD_PS     = 10000;
  // One beat per clock, so a 16-beat burst spacing is 16 clocks
  localparam int COL_TO_COL_DELAY_NCK      = 16;
  localparam int READ_TO_TRAIN_READ_DELAY_NS = 20;
  localparam int ROW_TO_COL_DELAY_NS       = 18;
  localparam int TRAINING_SELECT_BIT       = 6;
  localparam logic [5:0] TRN_RD_FIFO = 6'h01;
  localparam logic [5:0] TRN_RD_CAL  = 6'h03;
  localparam logic [5:0] TRN_WR_FIFO = 6'h07;
  localparam logic [7:0] REG_CMD          = 8'h00;
  localparam logic [7:0] REG_STATUS       = 8'h04;
  localparam logic [7:0] REG_WR_PATTERN   = 8'h08;
  localparam logic [7:0] REG_CAPTURE_BASE = 8'h40;
  localparam int STATUS_PEND_BIT  = 0;
  localparam int STATUS_WBUSY_BIT = 1;
  localparam int STATUS_CAP_LSB   = 4;

  typedef enum logic [3:0] {
    CMD_DES           = 4'h0,
    CMD_MULTI         = 4'h1,
    CMD_CAS2          = 4'h2,
    CMD_READ          = 4'h3,
    CMD_WRITE         = 4'h4,
    CMD_MASKED_WRITE  = 4'h5,
    CMD_MODE_REG_READ = 4'h6,
    CMD_PD_ENTRY      = 4'h7,
    CMD_SREF_PD_ENTRY = 4'h8,
    CMD_PD_EXIT       = 4'h9
  } dtf_cmd_type;

  typedef enum logic [2:0] {
    KIND_NONE          = 3'h0,
    KIND_CALIB         = 3'h1,
    KIND_FIFO_WR       = 3'h2,
    KIND_FIFO_RD       = 3'h3,
    KIND_READ          = 3'h4,
    KIND_PD_ENTER      = 3'h5,
    KIND_PD_EXIT       = 3'h6,
    KIND_SREF_PD_ENTER = 3'h7
  } dtf_kind_type;
endpackage : dtf_pkg

// *** logic/dtf_link_if.sv ***
`timescale 1ns/1ps
`default_nettype none
interface dtf_link_if;
  import dtf_pkg::*;
  dtf_cmd_type           cmd;
  logic [6:0]            cmd_op;
  logic [DQ_W-1:0]       dev_dq_o;
  logic                  dev_dq_oe;
  logic [MIL_W-1:0]      dev_mil_o;
  logic                  dev_mil_oe;
  logic                  dev_rdqs;
  logic [DQ_W-1:0]       ctl_dq_o;
  logic [MIL_W-1:0]      ctl_mil_o;
  logic                  ctl_dq_oe;
  logic [DQ_W-1:0]       dq_bus;
  logic [MIL_W-1:0]      mil_bus;

  // Undriven lanes resolve low so both ends always see clean levels
  assign dq_bus  = dev_dq_oe ? dev_dq_o : (ctl_dq_oe ? ctl_dq_o : '0);
  assign mil_bus = dev_mil_oe ? dev_mil_o : (ctl_dq_oe ? ctl_mil_o : '0);

  modport device (input cmd, cmd_op, dq_bus, mil_bus,
                  output dev_dq_o, dev_dq_oe, dev_mil_o, dev_mil_oe, dev_rdqs);
  modport controller (input dq_bus, mil_bus, dev_dq_oe, dev_rdqs,
                      output cmd, cmd_op, ctl_dq_o, ctl_mil_o, ctl_dq_oe);
endinterface : dtf_link_if
`default_nettype wire

// *** logic/dtf_controller.sv ***
`timescale 1ns/1ps
`default_nettype none
module dtf_controller
  import dtf_pkg::*;
#(
  parameter int P_WRITE_LATENCY    = WRITE_LATENCY_CYC,
  parameter int P_RD_TRAIN_GAP_NS  = READ_TO_TRAIN_READ_DELAY_NS,
  parameter int P_PD_EXIT_WAIT_NS  = ROW_TO_COL_DELAY_NS
) (
  input  wire logic        I_CLK,
  input  wire logic        I_RESETN,
  input  wire logic [7:0]  I_ADDR,
  input  wire logic [31:0] I_WDATA,
  input  wire logic        I_WR,
  input  wire logic        I_RD,
  output logic [31:0]      O_RDATA,
  dtf_link_if.controller   LINK
);
  if (P_WRITE_LATENCY < 2 || P_WRITE_LATENCY > 200) begin : g_bad_param
    $error("dtf_controller: write latency out of range");
  end

  localparam int CCD_CYC   = COL_TO_COL_DELAY_NCK;
  localparam int RTRRD_RAW = (P_RD_TRAIN_GAP_NS * 1000 + CLK_PERIOD_PS - 1) / CLK_PERIOD_PS;
  localparam int MRRI_RAW  = (P_PD_EXIT_WAIT_NS * 1000 + CLK_PERIOD_PS - 1) / CLK_PERIOD_PS;
  localparam int RTRRD_CYC = (RTRRD_RAW < 1) ? 1 : RTRRD_RAW;
  localparam int MRRI_CYC  = (MRRI_RAW < 1) ? 1 : MRRI_RAW;

  typedef enum logic [1:0] {C_IDLE = 2'b01, C_CAS = 2'b10} dtf_ctl_state_type;

  dtf_ctl_state_type  state_reg,   state_next;
  logic               pend_reg,    pend_next;
  dtf_kind_type       kind_reg,    kind_next;
  dtf_kind_type       last_reg,    last_next;
  logic [15:0]        since_reg,   since_next;
  logic [LANE_W-1:0]  pat_reg,     pat_next;
  dtf_cmd_type        cmd_reg,     cmd_next;
  logic [6:0]         op_reg,      op_next;
  logic [7:0]         wcnt_reg,    wcnt_next;
  logic               wact_reg,    wact_next;
  logic [3:0]         wbeat_reg,   wbeat_next;
  logic [LANE_W-1:0]  wdat_reg,    wdat_next;
  logic [4:0]         cidx_reg,    cidx_next;
  logic [LANE_W-1:0]  cap_reg  [BURST_BEATS];
  logic [LANE_W-1:0]  cap_next [BURST_BEATS];
  logic [31:0]        rdata_reg,   rdata_next;

  // Least spacing before the next command given the previous one
  function automatic logic [15:0] gap_need(input dtf_kind_type prev, input dtf_kind_type nxt);
    // calibration and ordinary read keep their distance
    if ((prev == KIND_CALIB && nxt == KIND_READ) || (prev == KIND_READ && nxt == KIND_CALIB)) begin
      return 16'(RTRRD_CYC);
    end else if (prev == KIND_PD_EXIT && nxt == KIND_CALIB) begin
      return 16'(MRRI_CYC);
    end
    return 16'(CCD_CYC);
  endfunction : gap_need

  always_comb begin
    state_next = state_reg;
    pend_next  = pend_reg;
    kind_next  = kind_reg;
    last_next  = last_reg;
    since_next = (since_reg == 16'hffff) ? since_reg : 16'(since_reg + 16'h1);
    cmd_next   = CMD_DES;
    op_next    = 7'h00;
    wcnt_next  = (wcnt_reg != 8'h00) ? 8'(wcnt_reg - 8'h01) : 8'h00;
    case (state_reg)
      C_IDLE: begin
        if (pend_reg && (17'(since_reg) + 17'h1 >= 17'(gap_need(last_reg, kind_reg)))) begin
          case (kind_reg)
            KIND_CALIB, KIND_FIFO_WR, KIND_FIFO_RD: begin
              cmd_next   = CMD_MULTI;
              op_next    = {1'b1, (kind_reg == KIND_CALIB) ? TRN_RD_CAL :
                                  (kind_reg == KIND_FIFO_WR) ? TRN_WR_FIFO : TRN_RD_FIFO};
              state_next = C_CAS;
            end
            KIND_READ:          cmd_next = CMD_READ;
            KIND_PD_ENTER:      cmd_next = CMD_PD_ENTRY;
            KIND_SREF_PD_ENTER: cmd_next = CMD_SREF_PD_ENTRY;
            KIND_PD_EXIT:       cmd_next = CMD_PD_EXIT;
            default:            cmd_next = CMD_DES;
          endcase
          if (state_next == C_IDLE) begin
            pend_next  = 1'b0;
            last_next  = kind_reg;
            since_next = 16'h0;
          end
        end
      end
      C_CAS: begin
        // CAS2 straight after the training command
        cmd_next = CMD_CAS2;
        op_next    = 7'h00;
        state_next = C_IDLE;
        pend_next  = 1'b0;
        last_next  = kind_reg;
        since_next = 16'h0;
        if (kind_reg == KIND_FIFO_WR) begin
          wcnt_next = 8'(P_WRITE_LATENCY + 1);
        end
      end
      default: state_next = C_IDLE;
    endcase
    if (I_WR && I_ADDR == REG_CMD && !pend_reg && I_WDATA[2:0] != 3'(KIND_NONE)) begin
      pend_next = 1'b1;
      kind_next = dtf_kind_type'(I_WDATA[2:0]);
    end
  end

  always_comb begin
    // write beats land where the device samples them
    wact_next  = (wcnt_reg == 8'h01) || (wact_reg && (wbeat_reg != 4'hf));
    wbeat_next = (wcnt_reg == 8'h01) ? 4'h0 : (wact_reg ? 4'(wbeat_reg + 4'h1) : 4'h0);
    wdat_next  = wact_next ? (pat_reg ^ LANE_W'(wbeat_next)) : '0;
    pat_next   = (I_WR && I_ADDR == REG_WR_PATTERN) ? I_WDATA[LANE_W-1:0] : pat_reg;
    cap_next   = cap_reg;
    cidx_next  = cidx_reg;
    if (state_reg == C_CAS && kind_reg != KIND_FIFO_WR) begin
      cidx_next = 5'h00;
    end else if (LINK.dev_dq_oe && cidx_reg < 5'(BURST_BEATS)) begin
      cap_next[cidx_reg[3:0]] = {LINK.mil_bus, LINK.dq_bus};
      cidx_next = 5'(cidx_reg + 5'h01);
    end
    rdata_next = 32'h0;
    if (I_RD) begin
      if (I_ADDR == REG_STATUS) begin
        rdata_next[STATUS_PEND_BIT]                    = pend_reg;
        rdata_next[STATUS_WBUSY_BIT]                   = wact_reg || (wcnt_reg != 8'h00);
        rdata_next[STATUS_CAP_LSB +: 5]                = cidx_reg;
      end else if (I_ADDR == REG_WR_PATTERN) begin
        rdata_next[LANE_W-1:0] = pat_reg;
      end else if (I_ADDR[7:6] == REG_CAPTURE_BASE[7:6] && I_ADDR[1:0] == 2'h0) begin
        rdata_next[LANE_W-1:0] = cap_reg[I_ADDR[5:2]];
      end
    end
  end

  always_ff @(posedge I_CLK) begin
    if (!I_RESETN) begin
      state_reg <= C_IDLE;
      pend_reg  <= 1'b0;
      kind_reg  <= KIND_NONE;
      last_reg  <= KIND_NONE;
      since_reg <= 16'hffff;
      pat_reg   <= '0;
      cmd_reg   <= CMD_DES;
      op_reg    <= 7'h00;
      wcnt_reg  <= 8'h00;
      wact_reg  <= 1'b0;
      wbeat_reg <= 4'h0;
      wdat_reg  <= '0;
      cidx_reg  <= 5'h00;
      rdata_reg <= 32'h0;
      for (int b = 0; b < BURST_BEATS; b++) begin
        cap_reg[b] <= '0;
      end
    end else begin
      state_reg <= state_next;
      pend_reg  <= pend_next;
      kind_reg  <= kind_next;
      last_reg  <= last_next;
      since_reg <= since_next;
      pat_reg   <= pat_next;
      cmd_reg   <= cmd_next;
      op_reg    <= op_next;
      wcnt_reg  <= wcnt_next;
      wact_reg  <= wact_next;
      wbeat_reg <= wbeat_next;
      wdat_reg  <= wdat_next;
      cidx_reg  <= cidx_next;
      rdata_reg <= rdata_next;
      cap_reg   <= cap_next;
    end
  end

  assign LINK.cmd       = cmd_reg;
  assign LINK.cmd_op    = op_reg;
  assign LINK.ctl_dq_o  = wdat_reg[DQ_W-1:0];
  assign LINK.ctl_mil_o = wdat_reg[LANE_W-1:DQ_W];
  assign LINK.ctl_dq_oe = wact_reg;
  assign O_RDATA        = rdata_reg;
endmodule : dtf_controller
`default_nettype wire

// *** bench/dtf_assertions.sv ***
`timescale 1ns/1ps
`default_nettype none
module dtf_assertions
  import dtf_pkg::*;
(
  input wire logic        I_CLK,
  input wire logic        I_RESETN,
  input wire dtf_cmd_type cmd,
  input wire logic [6:0]  cmd_op,
  input wire logic        dev_dq_oe,
  input wire logic        dev_mil_oe,
  input wire logic        dev_rdqs,
  input wire logic        ctl_dq_oe
);
  default clocking @(posedge I_CLK);
  endclocking
  default disable iff (!I_RESETN);
  // Seamless bursts may follow, so only the start and length are pinned
  property p_rd_burst;
    cmd == CMD_CAS2 && $past(cmd) == CMD_MULTI && $past(cmd_op) inside {7'h41, 7'h43}
      |-> ##9 dev_dq_oe [*8] ##1 dev_dq_oe [*8];
  endproperty
  a_rd_burst: assert property (p_rd_burst) else $error("read burst late or short");
  property p_wr_drive;
    cmd == CMD_CAS2 && $past(cmd) == CMD_MULTI && $past(cmd_op) == 7'h47
      |-> ##7 ctl_dq_oe [*8] ##1 ctl_dq_oe [*8];
  endproperty
  a_wr_drive: assert property (p_wr_drive) else $error("write data window wrong");
  property p_rdqs_pre;
    $rose(dev_dq_oe) |-> $past(dev_rdqs) != $past(dev_rdqs, 2);
  endproperty
  a_rdqs_pre: assert property (p_rdqs_pre) else $error("no toggling preamble");
  property p_rdqs_beat;
    dev_dq_oe |-> dev_rdqs != $past(dev_rdqs);
  endproperty
  a_rdqs_beat: assert property (p_rdqs_beat) else $error("strobe stopped in burst");
  property p_mil_oe;
    dev_mil_oe |-> dev_dq_oe;
  endproperty
  a_mil_oe: assert property (p_mil_oe) else $error("mask lane driven outside burst");
  property p_pair;
    cmd == CMD_MULTI && cmd_op[6] |=> cmd == CMD_CAS2;
  endproperty
  a_pair: assert property (p_pair) else $error("training command not paired");
  property p_cas2_low;
    cmd == CMD_CAS2 |-> cmd_op == 7'h00;
  endproperty
  a_cas2_low: assert property (p_cas2_low) else $error("column operands not low");
  property p_rtrrd;
    cmd == CMD_CAS2 && $past(cmd_op) == 7'h43 |=> cmd != CMD_READ;
  endproperty
  a_rtrrd: assert property (p_rtrrd) else $error("read too soon after calibration");
  property p_pd_exit;
    cmd == CMD_PD_EXIT |=> !(cmd == CMD_MULTI && cmd_op == 7'h43);
  endproperty
  a_pd_exit: assert property (p_pd_exit) else $error("calibration too soon after wake");
  // A burst may only follow a paired read-type training command
  property p_no_spur;
    $rose(dev_dq_oe) |-> $past(cmd, 9) == CMD_CAS2 && $past(cmd, 10) == CMD_MULTI &&
      $past(cmd_op, 10) inside {7'h41, 7'h43};
  endproperty
  a_no_spur: assert property (p_no_spur) else $error("read burst with no training command");
endmodule : dtf_assertions
`default_nettype wire

// *** bench/dtf_tb.sv ***
`timescale 1ns/1ps
`default_nettype none
module dtf_tb
  import dtf_pkg::*;
  ;
  logic        clk, rstn, wr, rd, md, wi, ri;
  logic [7:0]  addr, fb, sb, ml, mu;
  logic [31:0] wdata, rdata;
  logic [2:0]  wp, rp;
  int          failures, num_checks;

  dtf_link_if i_dtf_link_if ();
  dtf_device i_dtf_device (.I_CLK(clk), .I_RESETN(rstn), .LINK(i_dtf_link_if), .I_PATTERN_FIRST_BYTE(fb),
    .I_PATTERN_SECOND_BYTE(sb), .I_INVERT_MASK_LOWER_BYTE(ml), .I_INVERT_MASK_UPPER_BYTE(mu),
    .I_MASK_FUNCTION_DISABLE(md), .I_WRITE_INVERSION_EN(wi), .I_READ_INVERSION_EN(ri),
    .O_WR_PTR(wp), .O_RD_PTR(rp));
  dtf_controller i_dtf_controller (.I_CLK(clk), .I_RESETN(rstn), .I_ADDR(addr), .I_WDATA(wdata),
    .I_WR(wr), .I_RD(rd), .O_RDATA(rdata), .LINK(i_dtf_link_if));
  dtf_assertions i_dtf_assertions (.I_CLK(clk), .I_RESETN(rstn), .cmd(i_dtf_link_if.cmd),
    .cmd_op(i_dtf_link_if.cmd_op), .dev_dq_oe(i_dtf_link_if.dev_dq_oe),
    .dev_mil_oe(i_dtf_link_if.dev_mil_oe), .dev_rdqs(i_dtf_link_if.dev_rdqs),
    .ctl_dq_oe(i_dtf_link_if.ctl_dq_oe));

  initial begin
    clk = 1'b0;
    forever #5 clk = ~clk;
  end

  task automatic chk(input logic [31:0] g, input logic [31:0] e);
    num_checks++;
    if (g !== e) begin
      failures++;
      $display("BAD t=%0t got=%h exp=%h", $time, g, e);
    end
  endtask : chk

  task automatic reg_wr(input logic [7:0] a, input logic [31:0] d);
    @(posedge clk);
    addr <= a;
    wdata <= d;
    wr <= 1'b1;
    @(posedge clk);
    wr <= 1'b0;
  endtask : reg_wr

  // Read data stand only in the cycle after the strobe
  task automatic reg_rd(input logic [7:0] a, output logic [31:0] d);
    @(posedge clk);
    addr <= a;
    rd <= 1'b1;
    @(posedge clk);
    rd <= 1'b0;
    #1 d = rdata;
  endtask : reg_rd

  // Burst lands within RL+17 cycles of the link command, so 30 is ample
  task automatic run(input logic [2:0] k);
    logic [31:0] s;
    int n;
    reg_wr(REG_CMD, {29'h0, k});
    n = 0;
    do begin
      reg_rd(REG_STATUS, s);
      n++;
    end while ((s[STATUS_PEND_BIT] || s[STATUS_WBUSY_BIT]) && n < 50);
    chk(s & 32'h3, 32'h0);
    repeat (30) @(posedge clk);
  endtask : run

  task automatic calib(input logic [7:0] f, s, l, u, input logic d, w, r);
    logic [31:0] g;
    logic b;
    @(posedge clk);
    fb <= f;
    sb <= s;
    ml <= l;
    mu <= u;
    md <= d;
    wi <= w;
    ri <= r;
    run(KIND_CALIB);
    for (int i = 0; i < 16; i++) begin
      b = (i < 8) ? f[i] : s[i - 8];
      reg_rd(REG_CAPTURE_BASE + 8'(4 * i), g);
      chk(g, {14'h0, (d && !w && !r) ? 2'h0 : {2{b}}, {16{b}} ^ {u, l}});
    end
    $display("calibration burst done");
  endtask : calib

  function automatic logic [17:0] pat(input int k);
    return 18'h1e2d4 ^ 18'(k * 32'h2493);
  endfunction : pat

  task automatic t_fifo;
    logic [31:0] g;
    @(posedge clk);
    md <= 1'b0;
    for (int k = 0; k < 6; k++) begin
      reg_wr(REG_WR_PATTERN, {14'h0, pat(k)});
      run(KIND_FIFO_WR);
      chk({29'h0, wp}, (k + 1) % 5);
    end
    for (int k = 0; k < 6; k++) begin
      run(KIND_FIFO_RD);
      chk({29'h0, rp}, (k + 1) % 5);
      for (int b = 0; b < 16; b++) begin
        reg_rd(REG_CAPTURE_BASE + 8'(4 * b), g);
        chk(g, {14'h0, pat((k % 5 == 0) ? 5 : k) ^ 18'(b)});
      end
    end
    $display("fifo test done");
  endtask : t_fifo

  task automatic t_ptr;
    logic [31:0] g;
    reg_rd(8'hf0, g);
    chk(g, 32'h0);
    run(KIND_READ);
    chk({26'h0, wp, rp}, {26'h0, 3'h2, 3'h2});
    run(KIND_PD_ENTER);
    chk({26'h0, wp, rp}, 32'h0);
    run(KIND_READ);
    run(KIND_SREF_PD_ENTER);
    chk({26'h0, wp, rp}, 32'h0);
    // Entry zero is unwritten since the pointer reset but still holds pat(5) from the sixth FIFO write
    run(KIND_FIFO_RD);
    reg_rd(REG_CAPTURE_BASE, g);
    chk(g, {14'h0, pat(5)});
    run(KIND_PD_EXIT);
    calib(8'ha5, 8'h3c, 8'h81, 8'h18, 1'b0, 1'b1, 1'b0);
    $display("pointer test done");
  endtask : t_ptr

  task automatic give_verdict;
    $display("checks=%0d failures=%0d", num_checks, failures);
    if (failures == 0 && num_checks > 0)
      $display("STATUS OK");
    else
      $display("STATUS NOT OK");
    $finish;
  endtask : give_verdict

  initial begin
    repeat (20000) @(posedge clk);
    failures++;
    give_verdict();
  end

  initial begin
    {rstn, wr, rd, md, wi, ri} = 6'h0;
    {addr, fb, sb, ml, mu} = 40'h0;
    wdata = 32'h0;
    repeat (8) @(posedge clk);
    rstn <= 1'b1;
    @(posedge clk);
    #1 chk({26'h0, wp, rp}, 32'h0);
    calib(8'h1c, 8'h59, 8'h55, 8'h55, 1'b0, 1'b0, 1'b1);
    calib(8'h27, 8'hc3, 8'hf0, 8'h0f, 1'b1, 1'b0, 1'b0);
    calib(8'h81, 8'h7e, 8'h00, 8'hff, 1'b1, 1'b1, 1'b0);
    t_fifo();
    t_ptr();
    give_verdict();
  end
endmodule : dtf_tb
`default_nettype wire
